// ---- design/status_out_pkg.sv ----
// constants for the remote status output encoder
package status_out_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ROBOTS = 16;
    localparam int SEL_W = 5;
    localparam int FUNC_W = 6;
    localparam int ERRNUM_W = 14;
    localparam int BOXES = 15;
    localparam int ALARMS = 9;
    localparam int ADR_W = 8;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADR_W-1:0] FUNC_OFS = 8'h04;
    localparam logic [ADR_W-1:0] ERRNUM_OFS = 8'h08;
    localparam logic [ADR_W-1:0] STATUS_OFS = 8'h0C;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_STARTUP_BIT = 0;
    localparam int CTRL_TEACH_BIT = 1;
    localparam int CTRL_REMOTE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // ------------------------------------------------------------
    // default output positions of the status byte
    // ------------------------------------------------------------
    localparam int POS_READY = 0;
    localparam int POS_RUNNING = 1;
    localparam int POS_PAUSED = 2;
    localparam int POS_ERROR = 3;
    localparam int POS_ESTOP = 4;
    localparam int POS_SAFEGUARD = 5;
    localparam int POS_CRITICAL = 6;
    localparam int POS_WARNING = 7;
    localparam int STATUS_SEL_LSB = 8;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_ALL = 5'h00;
    localparam logic [FUNC_W-1:0] FUNC_RESET = 6'h00;
    localparam logic [ERRNUM_W-1:0] ERRNUM_RESET = 14'h0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : status_out_pkg

// ---- design/remote_status_outputs.sv ----
// remote status output encoder with classic wishbone control registers
`timescale 1ns/1ps

// Functional notes
// R1 - ready when started up and no task
// R2 - running while task runs, off when paused
// R3 - paused while any paused task exists
// R4 - error latched, cleared by remote reset input
// R5 - emergency stop output follows stop condition
// R6 - safeguard output follows open safeguard
// R7 - critical error sticky until controller reboot
// R8 - warning output, tasks keep running
// R9 - motors energized for selected robot
// R10 - home position for selected robot
// R11 - high power for selected robot
// R12 - calibration required for selected robot
// R13 - recovery required if any robot waits
// R14 - recovery in progress if any robot recovers
// R15 - command executing while remote command runs
// R16 - command rejected when command not accepted
// R17 - six bit current main function number
// R18 - remote acceptance while inputs accepted
// R19 - teach mode output in teach mode
// R20 - fourteen bit binary error number
// R21 - approach area and plane outputs
// R22 - alarm summary when any alarm active
// R23 - robot select latched, default all robots
// R24 - every output registered, one cycle after the core state inputs
module remote_status_outputs (
    input wire logic mclk_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [status_out_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // controller core state, same clock
    input wire logic task_running_i,
    input wire logic task_paused_i,
    input wire logic emergency_stop_i,
    input wire logic safeguard_i,
    input wire logic critical_event_i,
    input wire logic warning_i,
    input wire logic [status_out_pkg::ROBOTS-1:0] motor_on_i,
    input wire logic [status_out_pkg::ROBOTS-1:0] at_home_i,
    input wire logic [status_out_pkg::ROBOTS-1:0] power_high_i,
    input wire logic [status_out_pkg::ROBOTS-1:0] calibrated_i,
    input wire logic [status_out_pkg::ROBOTS-1:0] recovery_wait_i,
    input wire logic [status_out_pkg::ROBOTS-1:0] recovery_busy_i,
    input wire logic cmd_busy_i,
    input wire logic cmd_start_i,
    input wire logic cmd_refuse_i,
    input wire logic [status_out_pkg::BOXES-1:0] box_inside_i,
    input wire logic plane_inside_i,
    input wire logic [status_out_pkg::ALARMS-1:0] alarm_i,
    // remote pins from the external master
    input wire logic remote_reset_i,
    input wire logic [status_out_pkg::SEL_W-1:0] robot_select_i,
    input wire logic robot_select_set_i,
    // remote status outputs
    output logic ready_o,
    output logic running_o,
    output logic paused_o,
    output logic error_o,
    output logic emergency_stop_active_o,
    output logic safeguard_open_o,
    output logic critical_error_o,
    output logic warning_o,
    output logic motors_energized_o,
    output logic home_position_o,
    output logic high_power_o,
    output logic calibration_required_o,
    output logic recovery_required_o,
    output logic recovery_in_progress_o,
    output logic command_executing_o,
    output logic command_rejected_o,
    output logic [status_out_pkg::FUNC_W-1:0] current_function_bits_o,
    output logic remote_acceptance_o,
    output logic teach_mode_active_o,
    output logic [status_out_pkg::ERRNUM_W-1:0] error_number_bits_o,
    output logic [status_out_pkg::BOXES-1:0] approach_area_o,
    output logic approach_plane_o,
    output logic alarm_summary_o
);
    import status_out_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pick one robot's bit, or combine all robots when selection is zero
    function automatic logic pick_robot(input logic [ROBOTS-1:0] vec, input logic [SEL_W-1:0] sel,
                                        input logic all_and);
        logic r;
        r = 1'b0;
        if (sel == SEL_ALL) begin
            r = all_and ? (&vec) : (|vec);
        end else begin
            r = vec[4'(sel - 5'h01)];
        end
        return r;
    endfunction : pick_robot

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_prev_ff;
    logic [1:0] set_sync_ff;
    logic set_prev_ff;
    logic [SEL_W-1:0] sel_meta_ff;
    logic [SEL_W-1:0] sel_sync_ff;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_ff <= 2'b00;
            rst_prev_ff <= 1'b0;
            set_sync_ff <= 2'b00;
            set_prev_ff <= 1'b0;
            sel_meta_ff <= SEL_ALL;
            sel_sync_ff <= SEL_ALL;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], remote_reset_i};
            rst_prev_ff <= rst_sync_ff[1];
            set_sync_ff <= {set_sync_ff[0], robot_select_set_i};
            set_prev_ff <= set_sync_ff[1];
            sel_meta_ff <= robot_select_i;
            sel_sync_ff <= sel_meta_ff;
        end
    end

    logic remote_reset_rise;
    logic select_rise;
    assign remote_reset_rise = rst_sync_ff[1] & ~rst_prev_ff;
    assign select_rise = set_sync_ff[1] & ~set_prev_ff;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic [2:0] ctrl_ff;
    logic [FUNC_W-1:0] func_ff;
    logic [ERRNUM_W-1:0] errnum_ff;
    logic [SEL_W-1:0] robot_sel_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic bus_req;
    logic bus_wr;
    logic err_wr;

    assign bus_req = cyc_i & stb_i & ~ack_ff;
    assign bus_wr = bus_req & we_i & sel_i[0];
    assign err_wr = bus_wr & (adr_i == ERRNUM_OFS) & (dat_i[ERRNUM_W-1:0] != ERRNUM_RESET);

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_ff <= CTRL_RESET;
            func_ff <= FUNC_RESET;
            errnum_ff <= ERRNUM_RESET;
        end else if (bus_wr) begin
            case (adr_i)
                CTRL_OFS: ctrl_ff <= dat_i[2:0];
                FUNC_OFS: func_ff <= dat_i[FUNC_W-1:0];
                ERRNUM_OFS: begin
                    errnum_ff <= dat_i[ERRNUM_W-1:0]; // R20
                end
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // status byte in its default output positions
    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00;
        status_byte[POS_READY] = ready_o;
        status_byte[POS_RUNNING] = running_o;
        status_byte[POS_PAUSED] = paused_o;
        status_byte[POS_ERROR] = error_o;
        status_byte[POS_ESTOP] = emergency_stop_active_o;
        status_byte[POS_SAFEGUARD] = safeguard_open_o;
        status_byte[POS_CRITICAL] = critical_error_o;
        status_byte[POS_WARNING] = warning_o;
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dat_ff <= UNMAPPED_DATA;
        end else if (bus_req) begin
            case (adr_i)
                CTRL_OFS: dat_ff <= {29'h0000_0000, ctrl_ff};
                FUNC_OFS: dat_ff <= {26'h000_0000, func_ff};
                ERRNUM_OFS: dat_ff <= {18'h0_0000, errnum_ff};
                STATUS_OFS: dat_ff <= {19'h0_0000, robot_sel_ff, status_byte};
                default: dat_ff <= UNMAPPED_DATA;
            endcase
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // ------------------------------------------------------------
    // robot selection
    // ------------------------------------------------------------
    // selection survives until changed or until the controller resets
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            robot_sel_ff <= SEL_ALL; // R23
        end else if (select_rise) begin
            robot_sel_ff <= sel_sync_ff; // R23
        end
    end

    // ------------------------------------------------------------
    // latched conditions
    // ------------------------------------------------------------
    logic error_ff;
    logic critical_ff;
    logic reject_ff;

    // a new error in the reset cycle wins over the clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            error_ff <= 1'b0;
        end else if (err_wr) begin
            error_ff <= 1'b1; // R4
        end else if (remote_reset_rise) begin
            error_ff <= 1'b0; // R4
        end
    end

    // remote reset deliberately ignored: only a reboot clears it
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            critical_ff <= 1'b0;
        end else if (critical_event_i) begin
            critical_ff <= 1'b1; // R7
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reject_ff <= 1'b0;
        end else if (cmd_refuse_i) begin
            reject_ff <= 1'b1; // R16
        end else if (cmd_start_i) begin
            reject_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_o <= 1'b0;
            running_o <= 1'b0;
            paused_o <= 1'b0;
            warning_o <= 1'b0;
            emergency_stop_active_o <= 1'b0;
            safeguard_open_o <= 1'b0;
        end else begin
            ready_o <= ctrl_ff[CTRL_STARTUP_BIT] & ~task_running_i & ~task_paused_i; // R1
            running_o <= task_running_i & ~task_paused_i; // R2
            paused_o <= task_paused_i; // R3
            warning_o <= warning_i; // R8
            emergency_stop_active_o <= emergency_stop_i; // R5
            safeguard_open_o <= safeguard_i; // R6
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            error_o <= 1'b0;
            critical_error_o <= 1'b0;
            command_executing_o <= 1'b0;
            command_rejected_o <= 1'b0;
        end else begin
            error_o <= error_ff | err_wr; // R4 R24
            critical_error_o <= critical_ff | critical_event_i; // R7
            command_executing_o <= cmd_busy_i; // R15
            command_rejected_o <= reject_ff | cmd_refuse_i; // R16
        end
    end

    // all-robots view: motors, home, power need every robot; calibration any
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            motors_energized_o <= 1'b0;
            home_position_o <= 1'b0;
            high_power_o <= 1'b0;
            calibration_required_o <= 1'b0;
            recovery_required_o <= 1'b0;
            recovery_in_progress_o <= 1'b0;
        end else begin
            motors_energized_o <= pick_robot(motor_on_i, robot_sel_ff, 1'b1); // R9
            home_position_o <= pick_robot(at_home_i, robot_sel_ff, 1'b1); // R10
            high_power_o <= pick_robot(power_high_i, robot_sel_ff, 1'b1); // R11
            calibration_required_o <= pick_robot(~calibrated_i, robot_sel_ff, 1'b0); // R12
            recovery_required_o <= |recovery_wait_i; // R13
            recovery_in_progress_o <= |recovery_busy_i; // R14
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            current_function_bits_o <= FUNC_RESET;
            remote_acceptance_o <= 1'b0;
            teach_mode_active_o <= 1'b0;
            error_number_bits_o <= ERRNUM_RESET;
            approach_area_o <= '0;
            approach_plane_o <= 1'b0;
            alarm_summary_o <= 1'b0;
        end else begin
            current_function_bits_o <= func_ff; // R17
            remote_acceptance_o <= ctrl_ff[CTRL_REMOTE_BIT]; // R18
            teach_mode_active_o <= ctrl_ff[CTRL_TEACH_BIT]; // R19
            error_number_bits_o <= errnum_ff; // R20
            approach_area_o <= box_inside_i; // R21
            approach_plane_o <= plane_inside_i; // R21
            alarm_summary_o <= |alarm_i; // R22
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_err_set;
        err_wr;
    endsequence

    sequence s_clear_only;
        remote_reset_rise && !err_wr;
    endsequence

    ready_follow_a: assert property ( // R1
        ##1 ready_o == ($past(ctrl_ff[CTRL_STARTUP_BIT]) && !$past(task_running_i) && !$past(task_paused_i)))
        else $error("ready output wrong");
    run_pause_a: assert property (!(running_o && paused_o)) // R2
        else $error("running and paused together");
    paused_follow_a: assert property (task_paused_i |=> paused_o) // R3
        else $error("paused output missing");
    error_set_a: assert property (s_err_set |=> error_o ##1 error_o) // R4
        else $error("error not latched");
    error_clear_a: assert property (s_clear_only ##1 !err_wr |=> !error_o) // R4
        else $error("error not cleared");
    estop_follow_a: assert property (emergency_stop_i |=> emergency_stop_active_o) // R5
        else $error("stop output missing");
    guard_follow_a: assert property (safeguard_i |=> safeguard_open_o) // R6
        else $error("safeguard output missing");
    critical_hold_a: assert property (critical_error_o |=> critical_error_o) // R7
        else $error("critical error dropped");
    warning_follow_a: assert property (warning_i |=> warning_o) // R8
        else $error("warning output missing");
    reject_hold_a: assert property (cmd_refuse_i ##1 !cmd_start_i |=> command_rejected_o) // R16
        else $error("reject flag lost");
    alarm_any_a: assert property ((alarm_i != '0) |=> alarm_summary_o) // R22
        else $error("alarm summary missing");
    sel_keep_a: assert property (!select_rise |=> $stable(robot_sel_ff)) // R23
        else $error("robot select changed");
    recover_any_a: assert property ((recovery_wait_i != '0) |=> recovery_required_o) // R13
        else $error("recovery required missing");
endmodule : remote_status_outputs

// ---- testbench/remote_master_model.sv ----
// model of the external control device that drives the remote pins
`timescale 1ns/1ps

module remote_master_model (
    input wire logic mclk_i,
    output logic remote_reset_o,
    output logic [status_out_pkg::SEL_W-1:0] robot_select_o,
    output logic robot_select_set_o
);
    import status_out_pkg::*;
    // ------------------------------------------------------------
    // pin drive, held long enough for the two-flop synchronisers
    // ------------------------------------------------------------
    initial begin
        remote_reset_o = 1'b0;
        robot_select_o = SEL_ALL;
        robot_select_set_o = 1'b0;
    end

    // ordinary error is cleared only by a reset pulse from this side
    task clear_error();
        @(posedge mclk_i);
        remote_reset_o <= 1'b1;
        repeat (5) @(posedge mclk_i);
        remote_reset_o <= 1'b0;
        repeat (5) @(posedge mclk_i);
    endtask : clear_error

    // number settles before the strobe so the latch never sees a half value
    task select_robot(input logic [SEL_W-1:0] num);
        @(posedge mclk_i);
        robot_select_o <= num;
        repeat (4) @(posedge mclk_i);
        robot_select_set_o <= 1'b1;
        repeat (5) @(posedge mclk_i);
        robot_select_set_o <= 1'b0;
        repeat (5) @(posedge mclk_i);
    endtask : select_robot
endmodule : remote_master_model

// ---- testbench/test_remote_status_outputs.sv ----
// self-checking bench for the remote status output encoder
`timescale 1ns/1ps

module test_remote_status_outputs;
    import status_out_pkg::*;
    logic mclk_i = 1'b0, resetn_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [ADR_W-1:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic ack_o, task_running_i = 1'b0, task_paused_i = 1'b0, emergency_stop_i = 1'b0, safeguard_i = 1'b0;
    logic critical_event_i = 1'b0, warning_i = 1'b0, cmd_busy_i = 1'b0, cmd_start_i = 1'b0, cmd_refuse_i = 1'b0;
    logic [ROBOTS-1:0] motor_on_i = 16'h0000, at_home_i = 16'h0000, power_high_i = 16'h0000;
    logic [ROBOTS-1:0] calibrated_i = 16'hFFFF, recovery_wait_i = 16'h0000, recovery_busy_i = 16'h0000;
    logic [BOXES-1:0] box_inside_i = 15'h0000, approach_area_o;
    logic plane_inside_i = 1'b0, remote_reset_i, robot_select_set_i;
    logic [ALARMS-1:0] alarm_i = 9'h000;
    logic [SEL_W-1:0] robot_select_i;
    logic ready_o, running_o, paused_o, error_o, emergency_stop_active_o, safeguard_open_o, critical_error_o;
    logic warning_o, motors_energized_o, home_position_o, high_power_o, calibration_required_o;
    logic recovery_required_o, recovery_in_progress_o, command_executing_o, command_rejected_o;
    logic remote_acceptance_o, teach_mode_active_o, approach_plane_o, alarm_summary_o;
    logic [FUNC_W-1:0] current_function_bits_o;
    logic [ERRNUM_W-1:0] error_number_bits_o;
    logic [7:0] st;
    int n_fail = 0, checks_done = 0;

    assign st = {warning_o, critical_error_o, safeguard_open_o, emergency_stop_active_o,
                 error_o, paused_o, running_o, ready_o};
    always #25 mclk_i = ~mclk_i;

    remote_status_outputs i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .task_running_i(task_running_i), .task_paused_i(task_paused_i), .emergency_stop_i(emergency_stop_i),
        .safeguard_i(safeguard_i), .critical_event_i(critical_event_i), .warning_i(warning_i),
        .motor_on_i(motor_on_i), .at_home_i(at_home_i), .power_high_i(power_high_i), .calibrated_i(calibrated_i),
        .recovery_wait_i(recovery_wait_i), .recovery_busy_i(recovery_busy_i), .cmd_busy_i(cmd_busy_i),
        .cmd_start_i(cmd_start_i), .cmd_refuse_i(cmd_refuse_i), .box_inside_i(box_inside_i),
        .plane_inside_i(plane_inside_i), .alarm_i(alarm_i), .remote_reset_i(remote_reset_i),
        .robot_select_i(robot_select_i), .robot_select_set_i(robot_select_set_i), .ready_o(ready_o),
        .running_o(running_o), .paused_o(paused_o), .error_o(error_o),
        .emergency_stop_active_o(emergency_stop_active_o), .safeguard_open_o(safeguard_open_o),
        .critical_error_o(critical_error_o), .warning_o(warning_o), .motors_energized_o(motors_energized_o),
        .home_position_o(home_position_o), .high_power_o(high_power_o),
        .calibration_required_o(calibration_required_o), .recovery_required_o(recovery_required_o),
        .recovery_in_progress_o(recovery_in_progress_o), .command_executing_o(command_executing_o),
        .command_rejected_o(command_rejected_o), .current_function_bits_o(current_function_bits_o),
        .remote_acceptance_o(remote_acceptance_o), .teach_mode_active_o(teach_mode_active_o),
        .error_number_bits_o(error_number_bits_o), .approach_area_o(approach_area_o),
        .approach_plane_o(approach_plane_o), .alarm_summary_o(alarm_summary_o));

    remote_master_model i_master (.mclk_i(mclk_i), .remote_reset_o(remote_reset_i),
        .robot_select_o(robot_select_i), .robot_select_set_o(robot_select_set_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task end_of_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // stimulus lands on an edge; the next edge takes it, the one after reads the registered output
    task settle();
        repeat (2) @(posedge mclk_i);
    endtask : settle

    task wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    initial begin
        #1_000_000;
        n_fail++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        settle();
        chk(st, 8'h00);
        wb(1'b1, CTRL_OFS, 32'h0000_0001);
        settle();
        chk(st, 8'h01);
        chk({teach_mode_active_o, remote_acceptance_o}, 2'b00);
        wb(1'b1, CTRL_OFS, 32'h0000_0007);
        settle();
        chk({teach_mode_active_o, remote_acceptance_o}, 2'b11);
        task_running_i <= 1'b1;
        warning_i <= 1'b1;
        settle();
        chk(st, 8'h82);
        task_paused_i <= 1'b1;
        settle();
        chk(st, 8'h84);
        wb(1'b0, STATUS_OFS, 32'h0000_0000);
        chk(q[12:0], 13'h0084);
        task_running_i <= 1'b0;
        task_paused_i <= 1'b0;
        warning_i <= 1'b0;
        emergency_stop_i <= 1'b1;
        safeguard_i <= 1'b1;
        settle();
        chk(st, 8'h31);
        emergency_stop_i <= 1'b0;
        safeguard_i <= 1'b0;
        wb(1'b1, ERRNUM_OFS, 32'h0000_3FFF);
        settle();
        chk(error_number_bits_o, 14'h3FFF);
        chk(st, 8'h09);
        i_master.clear_error();
        chk(st, 8'h01);
        critical_event_i <= 1'b1;
        @(posedge mclk_i);
        critical_event_i <= 1'b0;
        settle();
        chk(st, 8'h41);
        i_master.clear_error();
        chk(st, 8'h41);
        wb(1'b1, FUNC_OFS, 32'h0000_003F);
        settle();
        chk(current_function_bits_o, 6'h3F);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk(q, UNMAPPED_DATA);
        wb(1'b1, STATUS_OFS, 32'h0000_FFFF);
        wb(1'b0, STATUS_OFS, 32'h0000_0000);
        chk(q[12:0], 13'h0041);
        motor_on_i <= 16'hFFFF;
        at_home_i <= 16'hFFFE;
        power_high_i <= 16'h0004;
        calibrated_i <= 16'hFFFB;
        settle();
        chk({motors_energized_o, home_position_o, high_power_o, calibration_required_o}, 4'b1001);
        i_master.select_robot(5'h03);
        at_home_i <= 16'h0004;
        motor_on_i <= 16'h0004;
        settle();
        chk({motors_energized_o, home_position_o, high_power_o, calibration_required_o}, 4'b1111);
        calibrated_i <= 16'h0004;
        settle();
        chk(calibration_required_o, 1'b0);
        recovery_wait_i <= 16'h8000;
        recovery_busy_i <= 16'h0001;
        cmd_busy_i <= 1'b1;
        settle();
        chk({recovery_required_o, recovery_in_progress_o, command_executing_o}, 3'b111);
        recovery_wait_i <= 16'h0000;
        recovery_busy_i <= 16'h0000;
        cmd_busy_i <= 1'b0;
        cmd_refuse_i <= 1'b1;
        @(posedge mclk_i);
        cmd_refuse_i <= 1'b0;
        repeat (3) settle();
        chk({recovery_required_o, recovery_in_progress_o, command_executing_o, command_rejected_o}, 4'b0001);
        cmd_start_i <= 1'b1;
        @(posedge mclk_i);
        cmd_start_i <= 1'b0;
        settle();
        chk(command_rejected_o, 1'b0);
        box_inside_i <= 15'h4001;
        plane_inside_i <= 1'b1;
        alarm_i <= 9'h100;
        settle();
        chk({approach_area_o, approach_plane_o, alarm_summary_o}, 17'h1_0007);
        alarm_i <= 9'h000;
        settle();
        chk(alarm_summary_o, 1'b0);
        resetn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        settle();
        chk(st, 8'h00);
        end_of_test();
    end
endmodule : test_remote_status_outputs
